// >>> src/t16wm_top.sv
// Waveform mode control of a 16-bit timer with two compare output channels.
//
// Summary of operation
// - Control register: channel A mode, low mode bits.
// - Channel B output mode in bits 5:4.
// - Nonzero output mode takes the pin over, except a refused toggle.
// - Pin driver enabled only by direction bit.
// - Non-PWM codes: off, toggle, clear, set on match.
// - Fast code 2: clear on match, set at bottom.
// - Fast code 3: set on match, clear at bottom.
// - Fast toggle only channel A, modes 14, 15.
// - Fast codes 2, 3: match at TOP ignored, bottom action kept.
// - Dual toggle only channel A, modes 9, 11.
// - Dual code 2: clear up, set down.
// - Dual code 3: set up, clear down.
// - Four mode bits pick sequence, TOP, waveform.
// - Normal and clear-on-match: immediate update, flag at MAX.
// - Phase correct: update at TOP, flag at BOTTOM.
// - Fast PWM: update at BOTTOM, flag at TOP.
// - Frequency correct: update and flag at BOTTOM.
// - High mode bits sit in second control register.
// - Dual slope counts up to TOP, then down.
`default_nettype none
`include "t16wm_regs.svh"
module t16wm_top
	import t16wm_pkg::*;
(
	// Clock and reset.
	input  wire logic        SYS_CLK_I,
	input  wire logic        RESET_I,
	// Avalon-MM slave.
	input  wire logic [11:0] AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	// Timer clock enable from the prescaler.
	input  wire logic        TIMER_CLK_EN_I,
	// Port function of the two pins.
	input  wire logic        CHAN_A_DDR_I,
	input  wire logic        CHAN_A_PORT_I,
	input  wire logic        CHAN_B_DDR_I,
	input  wire logic        CHAN_B_PORT_I,
	// Pin drive.
	output logic             CHAN_A_WAVE_OUT_O,
	output logic             CHAN_A_WAVE_OE_O,
	output logic             CHAN_B_WAVE_OUT_O,
	output logic             CHAN_B_WAVE_OE_O,
	// Timer state.
	output logic             OVERFLOW_FLAG_O,
	output logic      [15:0] COUNTER_VALUE_O
);

	t16wm_bus_req_t req;              // Bundled bus request.
	logic          ack_ff;            // High in the cycle the request is accepted.
	logic [31:0]   rdata_ff;          // Read data register.
	logic [7:0]    ctrl_a_ff;         // First control register.
	logic [1:0]    wgm_hi_ff;         // High waveform mode bits.
	logic [15:0]   cnt_ff;            // Counter value.
	logic          down_ff;           // Counting downward.
	logic [15:0]   cmp_a_buf_ff;      // Compare A as written by software.
	logic [15:0]   cmp_b_buf_ff;      // Compare B as written by software.
	logic [15:0]   cmp_a_ff;          // Compare A in use.
	logic [15:0]   cmp_b_ff;          // Compare B in use.
	logic [15:0]   cap_ff;            // Capture value, software loaded.
	logic          ovf_ff;            // Overflow flag.
	logic          pin_a_ff;          // Registered pin A level.
	logic          pin_b_ff;          // Registered pin B level.
	logic          oe_a_ff;           // Registered pin A enable.
	logic          oe_b_ff;           // Registered pin B enable.
	logic [15:0]   nxt_cnt;           // Next counter value.
	logic          nxt_down;          // Next count direction.
	logic          wave_a;            // Channel A waveform.
	logic          wave_b;            // Channel B waveform.
	logic          conn_a;            // Channel A owns its pin.
	logic          conn_b;            // Channel B owns its pin.

	assign req = '{rd: AVS_READ_I, wr: AVS_WRITE_I, addr: AVS_ADDRESS_I,
		be: AVS_BYTEENABLE_I, wdata: AVS_WRITEDATA_I};

	// Address decode on the word index.
	wire [9:0] idx      = req.addr[11:2];
	wire       sel_ctla = idx == `T16WM_IDX_CTRL_A;
	wire       sel_ctlb = idx == `T16WM_IDX_CTRL_B;
	wire       sel_cnt  = idx == `T16WM_IDX_COUNT;
	wire       sel_cap  = idx == `T16WM_IDX_CAPTURE;
	wire       sel_cmpa = idx == `T16WM_IDX_CMP_A;
	wire       sel_cmpb = idx == `T16WM_IDX_CMP_B;
	wire       sel_stat = idx == `T16WM_IDX_STATUS;
	// Every request waits one cycle; the write lands at the accepting edge.
	wire       req_any  = req.rd | req.wr;
	wire       wr_go    = req.wr & ack_ff;
	wire       wr_lo    = wr_go & req.be[0];
	wire       wr_cnt   = wr_go & sel_cnt & (req.be[1] | req.be[0]);
	wire       ovf_clr  = wr_lo & sel_stat & req.wdata[`T16WM_OVF_BIT];
	assign AVS_WAITREQUEST_O = req_any & ~ack_ff;

	// Waveform mode assembled from both control registers.
	wire [3:0]    mode = {wgm_hi_ff, ctrl_a_ff[`T16WM_WGM_LO_HI:`T16WM_WGM_LO_LO]};
	wire t16wm_class_t cls = t16wm_class_of(mode);
	wire [1:0]    com_a = ctrl_a_ff[`T16WM_COM_A_HI:`T16WM_COM_A_LO];
	wire [1:0]    com_b = ctrl_a_ff[`T16WM_COM_B_HI:`T16WM_COM_B_LO];
	wire          dual  = (cls == T16WM_PC) || (cls == T16WM_PFC);

	// TOP source per mode.
	wire [15:0] top_val =
		(mode == `T16WM_M_PC8 || mode == `T16WM_M_FAST8) ? `T16WM_TOP_8BIT :
		(mode == `T16WM_M_PC9 || mode == `T16WM_M_FAST9) ? `T16WM_TOP_9BIT :
		(mode == `T16WM_M_PC10 || mode == `T16WM_M_FAST10) ? `T16WM_TOP_10BIT :
		(mode == `T16WM_M_CTC_CMP || mode == `T16WM_M_PFC_CMP ||
		mode == `T16WM_M_PC_CMP || mode == `T16WM_M_FAST_CMP) ? cmp_a_ff :
		(mode == `T16WM_M_CTC_CAP || mode == `T16WM_M_PFC_CAP ||
		mode == `T16WM_M_PC_CAP || mode == `T16WM_M_FAST_CAP) ? cap_ff :
		`T16WM_MAX;

	// Counter events; each counts only with the timer clock enable.
	wire        tick   = TIMER_CLK_EN_I;
	wire        at_top = cnt_ff == top_val;
	wire        at_bot = cnt_ff == `T16WM_BOTTOM;
	wire        at_max = cnt_ff == `T16WM_MAX;
	wire [15:0] cnt_inc = cnt_ff + `T16WM_ONE;
	wire [15:0] cnt_dec = cnt_ff - `T16WM_ONE;
	// A counter write removes the compare match of that cycle.
	wire        match_a = tick & ~wr_cnt & (cnt_ff == cmp_a_ff);
	wire        match_b = tick & ~wr_cnt & (cnt_ff == cmp_b_ff);
	// At TOP a dual-slope match acts as downward, at BOTTOM as upward.
	wire        eff_down = (down_ff & ~at_bot) | at_top;

	// Compare reload moments per family.
	wire upd_now = (cls == T16WM_NORMAL) || (cls == T16WM_CTC);
	wire upd_ev  = upd_now | (tick & ((cls == T16WM_PC) & at_top |
		((cls == T16WM_FAST) | (cls == T16WM_PFC)) & at_bot));
	// Overflow moments per family.
	wire ovf_set = tick & (upd_now & at_max |
		(cls == T16WM_FAST) & at_top | dual & at_bot);

	// Read multiplexer; unmapped addresses read zero.
	wire [31:0] rd_mux =
		sel_ctla ? {24'h000000, ctrl_a_ff} :
		sel_ctlb ? {24'h000000, 3'h0, wgm_hi_ff, 3'h0} :
		sel_cnt  ? {16'h0000, cnt_ff} :
		sel_cap  ? {16'h0000, cap_ff} :
		sel_cmpa ? {16'h0000, cmp_a_buf_ff} :
		sel_cmpb ? {16'h0000, cmp_b_buf_ff} :
		sel_stat ? {31'h0, ovf_ff} : 32'h00000000;

	// Counter sequence: software write first, then the timer clock enable.
	always_comb
	begin
		nxt_cnt  = cnt_ff;
		nxt_down = down_ff;
		if (wr_cnt)
			nxt_cnt = t16wm_merge16(cnt_ff, req.wdata, req.be);
		else if (tick)
		begin
			if (!dual)
			begin
				nxt_down = 1'b0;
				nxt_cnt  = at_top ? `T16WM_BOTTOM : cnt_inc;
			end
			else if (down_ff && !at_bot)
				nxt_cnt = cnt_dec;
			else if (down_ff)
			begin
				nxt_down = 1'b0;
				nxt_cnt  = cnt_inc;
			end
			else if (at_top)
			begin
				nxt_down = 1'b1;
				nxt_cnt  = cnt_dec;
			end
			else
				nxt_cnt = cnt_inc;
		end
	end

	// Bus handshake and read data capture.
	always_ff @(posedge SYS_CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			ack_ff <= req_any & ~ack_ff;
			if (req.rd & ~ack_ff)
				rdata_ff <= rd_mux;
		end
	end
	assign AVS_READDATA_O = rdata_ff;

	// Control registers; reserved bits 3:2 are never stored.
	always_ff @(posedge SYS_CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			ctrl_a_ff <= `T16WM_CTRL_A_RST;
			wgm_hi_ff <= `T16WM_WGM_HI_RST;
		end
		else
		begin
			if (wr_lo & sel_ctla)
				ctrl_a_ff <= req.wdata[7:0] & `T16WM_CTRL_A_WMASK;
			if (wr_lo & sel_ctlb)
				wgm_hi_ff <= req.wdata[`T16WM_WGM_HI_HI:`T16WM_WGM_HI_LO];
		end
	end

	// Compare buffers, capture value and reload into the active compare values.
	always_ff @(posedge SYS_CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			cmp_a_buf_ff <= `T16WM_BOTTOM;
			cmp_b_buf_ff <= `T16WM_BOTTOM;
			cmp_a_ff     <= `T16WM_BOTTOM;
			cmp_b_ff     <= `T16WM_BOTTOM;
			cap_ff       <= `T16WM_BOTTOM;
		end
		else
		begin
			if (wr_go & sel_cmpa)
				cmp_a_buf_ff <= t16wm_merge16(cmp_a_buf_ff, req.wdata, req.be);
			if (wr_go & sel_cmpb)
				cmp_b_buf_ff <= t16wm_merge16(cmp_b_buf_ff, req.wdata, req.be);
			if (wr_go & sel_cap)
				cap_ff <= t16wm_merge16(cap_ff, req.wdata, req.be);
			if (upd_ev)
			begin
				cmp_a_ff <= cmp_a_buf_ff;
				cmp_b_ff <= cmp_b_buf_ff;
			end
		end
	end

	// Counter, direction and overflow flag; a new overflow wins over its clear.
	always_ff @(posedge SYS_CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			cnt_ff  <= `T16WM_BOTTOM;
			down_ff <= 1'b0;
			ovf_ff  <= 1'b0;
		end
		else
		begin
			cnt_ff  <= nxt_cnt;
			down_ff <= nxt_down;
			ovf_ff  <= ovf_set | (ovf_ff & ~ovf_clr);
		end
	end

	// Compare channel A.
	t16wm_chan #(.IS_CHAN_A(1'b1)) u_chan_a (
		.clk_i       (SYS_CLK_I),
		.rst_i       (RESET_I),
		.match_i     (match_a),
		.bottom_i    (tick & at_bot),
		.down_i      (eff_down),
		.cmp_top_i   (cmp_a_ff == top_val),
		.cls_i       (cls),
		.mode_i      (mode),
		.com_i       (com_a),
		.wave_o      (wave_a),
		.connected_o (conn_a)
	);

	// Compare channel B.
	t16wm_chan #(.IS_CHAN_A(1'b0)) u_chan_b (
		.clk_i       (SYS_CLK_I),
		.rst_i       (RESET_I),
		.match_i     (match_b),
		.bottom_i    (tick & at_bot),
		.down_i      (eff_down),
		.cmp_top_i   (cmp_b_ff == top_val),
		.cls_i       (cls),
		.mode_i      (mode),
		.com_i       (com_b),
		.wave_o      (wave_b),
		.connected_o (conn_b)
	);

	// Pin stage: waveform replaces the port level, the direction bit enables the driver.
	always_ff @(posedge SYS_CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			pin_a_ff <= 1'b0;
			pin_b_ff <= 1'b0;
			oe_a_ff  <= 1'b0;
			oe_b_ff  <= 1'b0;
		end
		else
		begin
			pin_a_ff <= conn_a ? wave_a : CHAN_A_PORT_I;
			pin_b_ff <= conn_b ? wave_b : CHAN_B_PORT_I;
			oe_a_ff  <= CHAN_A_DDR_I;
			oe_b_ff  <= CHAN_B_DDR_I;
		end
	end
	assign CHAN_A_WAVE_OUT_O = pin_a_ff;
	assign CHAN_B_WAVE_OUT_O = pin_b_ff;
	assign CHAN_A_WAVE_OE_O  = oe_a_ff;
	assign CHAN_B_WAVE_OE_O  = oe_b_ff;
	assign OVERFLOW_FLAG_O   = ovf_ff;
	assign COUNTER_VALUE_O   = cnt_ff;

	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (RESET_I);

	ctrl_rsv_zero_a: assert property (ctrl_a_ff[3:2] == 2'h0) else $error("reserved bits set");
	pin_route_a: assert property (##1 CHAN_A_WAVE_OUT_O == ($past(conn_a) ? $past(wave_a)
		: $past(CHAN_A_PORT_I))) else $error("pin a routing wrong");
	pin_oe_a: assert property (##1 CHAN_B_WAVE_OE_O == $past(CHAN_B_DDR_I))
		else $error("pin b enable wrong");
	single_wrap_a: assert property (tick && !dual && at_top && !wr_cnt
		|=> cnt_ff == `T16WM_BOTTOM) else $error("no wrap after top");
	dual_turn_a: assert property (tick && dual && !down_ff && at_top && !at_bot && !wr_cnt
		|=> down_ff && cnt_ff == $past(cnt_dec)) else $error("no turn at top");
	ovf_fast_a: assert property (tick && cls == T16WM_FAST && at_top |=> ovf_ff)
		else $error("fast overflow missed");
	ovf_max_a: assert property (tick && upd_now && at_max |=> ovf_ff)
		else $error("overflow at max missed");
	ovf_bottom_a: assert property (tick && dual && at_bot |=> ovf_ff)
		else $error("overflow at bottom missed");
	reload_top_a: assert property (tick && cls == T16WM_PC && at_top
		|=> cmp_a_ff == $past(cmp_a_buf_ff)) else $error("no reload at top");
	hold_pfc_a: assert property (cls == T16WM_PFC && !(tick && at_bot) |=> $stable(cmp_b_ff))
		else $error("compare reload off bottom");
	bus_wait_a: assert property (req_any && !ack_ff |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
		else $error("wait state wrong");
	fast_run_c: cover property (cls == T16WM_FAST && tick && at_top ##[1:300] tick && at_bot);
	dual_turn_c: cover property (dual && tick && at_top && !down_ff);
	ovf_clr_c: cover property (ovf_set && ovf_clr);

endmodule
`default_nettype wire

// >>> include/t16wm_regs.svh
// Register indices, field positions, reset values and mode codes of the waveform timer.
`ifndef T16WM_REGS_SVH
`define T16WM_REGS_SVH

// Register indices; the byte address is four times the index.
`define T16WM_IDX_CTRL_A   10'h080
`define T16WM_IDX_CTRL_B   10'h081
`define T16WM_IDX_COUNT    10'h084
`define T16WM_IDX_CAPTURE  10'h086
`define T16WM_IDX_CMP_A    10'h088
`define T16WM_IDX_CMP_B    10'h08A
`define T16WM_IDX_STATUS   10'h090

// Field positions in the first control register.
`define T16WM_COM_A_HI     7
`define T16WM_COM_A_LO     6
`define T16WM_COM_B_HI     5
`define T16WM_COM_B_LO     4
`define T16WM_WGM_LO_HI    1
`define T16WM_WGM_LO_LO    0
// Field position of the high mode bits in the second control register.
`define T16WM_WGM_HI_HI    4
`define T16WM_WGM_HI_LO    3
// Overflow flag bit in the status register.
`define T16WM_OVF_BIT      0

// Writable bits of the first control register; bits 3:2 always read zero.
`define T16WM_CTRL_A_WMASK 8'hF3
`define T16WM_CTRL_A_RST   8'h00
`define T16WM_WGM_HI_RST   2'h0

// Counter values.
`define T16WM_BOTTOM       16'h0000
`define T16WM_MAX          16'hFFFF
`define T16WM_ONE          16'h0001
`define T16WM_TOP_8BIT     16'h00FF
`define T16WM_TOP_9BIT     16'h01FF
`define T16WM_TOP_10BIT    16'h03FF

// Waveform mode codes.
`define T16WM_M_NORMAL     4'h0
`define T16WM_M_PC8        4'h1
`define T16WM_M_PC9        4'h2
`define T16WM_M_PC10       4'h3
`define T16WM_M_CTC_CMP    4'h4
`define T16WM_M_FAST8      4'h5
`define T16WM_M_FAST9      4'h6
`define T16WM_M_FAST10     4'h7
`define T16WM_M_PFC_CAP    4'h8
`define T16WM_M_PFC_CMP    4'h9
`define T16WM_M_PC_CAP     4'hA
`define T16WM_M_PC_CMP     4'hB
`define T16WM_M_CTC_CAP    4'hC
`define T16WM_M_FAST_CAP   4'hE
`define T16WM_M_FAST_CMP   4'hF

// Output mode codes of a compare channel.
`define T16WM_COM_OFF      2'h0
`define T16WM_COM_TOGGLE   2'h1
`define T16WM_COM_CLEAR    2'h2
`define T16WM_COM_SET      2'h3

`endif

// >>> include/t16wm_pkg.sv
// Types and helper functions shared by the waveform timer modules.
`default_nettype none
`include "t16wm_regs.svh"
package t16wm_pkg;

	// Counting family selected by the waveform mode.
	typedef enum logic [2:0] {T16WM_NORMAL, T16WM_CTC, T16WM_FAST, T16WM_PC, T16WM_PFC} t16wm_class_t;

	// One Avalon-MM request as seen by the slave.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} t16wm_bus_req_t;

	// Maps a 4-bit waveform mode onto its counting family; the reserved code counts normally.
	function automatic t16wm_class_t t16wm_class_of(input logic [3:0] mode);
		case (mode)
			`T16WM_M_CTC_CMP, `T16WM_M_CTC_CAP: return T16WM_CTC;
			`T16WM_M_FAST8, `T16WM_M_FAST9, `T16WM_M_FAST10,
			`T16WM_M_FAST_CAP, `T16WM_M_FAST_CMP: return T16WM_FAST;
			`T16WM_M_PC8, `T16WM_M_PC9, `T16WM_M_PC10,
			`T16WM_M_PC_CAP, `T16WM_M_PC_CMP: return T16WM_PC;
			`T16WM_M_PFC_CAP, `T16WM_M_PFC_CMP: return T16WM_PFC;
			default: return T16WM_NORMAL;
		endcase
	endfunction

	// Merges the two low byte lanes of a write into a 16-bit register.
	function automatic logic [15:0] t16wm_merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

endpackage
`default_nettype wire

// >>> src/t16wm_chan.sv
// One compare output channel: waveform flip-flop and pin connection decision.
`default_nettype none
`include "t16wm_regs.svh"
module t16wm_chan
	import t16wm_pkg::*;
#(
	parameter bit IS_CHAN_A = 1'b1
)
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Counter events; match and bottom already qualified by the timer clock enable.
	input  wire logic        match_i,
	input  wire logic        bottom_i,
	input  wire logic        down_i,
	input  wire logic        cmp_top_i,
	// Configuration.
	input  wire t16wm_class_t cls_i,
	input  wire logic [3:0]  mode_i,
	input  wire logic [1:0]  com_i,
	// Results.
	output logic             wave_o,
	output logic             connected_o
);

	logic wave_ff;   // Waveform state of the channel.
	logic nxt_wave;  // Next waveform state.

	// Family decodes.
	wire is_fast = cls_i == T16WM_FAST;
	wire is_dual = (cls_i == T16WM_PC) || (cls_i == T16WM_PFC);
	wire is_pwm  = is_fast || is_dual;
	// Toggle in a PWM family is reserved for channel A, in fast modes 14 and 15 and dual modes 9 and 11.
	wire tog_fast = IS_CHAN_A && ((mode_i == `T16WM_M_FAST_CAP) || (mode_i == `T16WM_M_FAST_CMP));
	wire tog_dual = IS_CHAN_A && ((mode_i == `T16WM_M_PFC_CMP) || (mode_i == `T16WM_M_PC_CMP));
	wire tog_ok   = !is_pwm || (is_fast && tog_fast) || (is_dual && tog_dual);
	// The pin is taken over for any nonzero code except a refused toggle.
	assign connected_o = (com_i != `T16WM_COM_OFF) && !((com_i == `T16WM_COM_TOGGLE) && !tog_ok);
	assign wave_o = wave_ff;

	// Next waveform value from the output mode code and the counting family.
	always_comb
	begin
		nxt_wave = wave_ff;
		case (com_i)
			`T16WM_COM_TOGGLE:
				if (match_i && tog_ok)
					nxt_wave = ~wave_ff;
			`T16WM_COM_CLEAR:
				if (is_fast)
				begin
					// A match wins over BOTTOM, except the ignored match at TOP.
					if (match_i && !cmp_top_i)
						nxt_wave = 1'b0;
					else if (bottom_i)
						nxt_wave = 1'b1;
				end
				else if (is_dual)
				begin
					if (match_i)
						nxt_wave = down_i;
				end
				else if (match_i)
					nxt_wave = 1'b0;
			`T16WM_COM_SET:
				if (is_fast)
				begin
					if (match_i && !cmp_top_i)
						nxt_wave = 1'b1;
					else if (bottom_i)
						nxt_wave = 1'b0;
				end
				else if (is_dual)
				begin
					if (match_i)
						nxt_wave = ~down_i;
				end
				else if (match_i)
					nxt_wave = 1'b1;
			default:
				nxt_wave = wave_ff;
		endcase
	end

	// Waveform register.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			wave_ff <= 1'b0;
		else
			wave_ff <= nxt_wave;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Non-PWM toggle flips the output on every match.
	ctc_toggle_a: assert property (!is_pwm && com_i == `T16WM_COM_TOGGLE && match_i
		|=> wave_ff != $past(wave_ff)) else $error("toggle on match missed");
	// Fast PWM non-inverting sets at BOTTOM when no match stands.
	fast_bottom_a: assert property (is_fast && com_i == `T16WM_COM_CLEAR && bottom_i && !match_i
		|=> wave_ff) else $error("fast pwm not set at bottom");
	// Fast PWM ignores a match at TOP with the upper code bit set.
	fast_topmatch_a: assert property (is_fast && com_i[1] && match_i && cmp_top_i && !bottom_i
		|=> $stable(wave_ff)) else $error("match at top not ignored");
	// Dual slope inverting follows the count direction on a match.
	dual_set_a: assert property (is_dual && com_i == `T16WM_COM_SET && match_i
		|=> wave_ff == !$past(down_i)) else $error("dual slope inverting wrong");
	// Channel B never connects for a PWM toggle code.
	b_tog_off_a: assert property (!IS_CHAN_A && is_pwm && com_i == `T16WM_COM_TOGGLE
		|-> !connected_o) else $error("channel b toggle connected");
	toggle_c: cover property (is_pwm && tog_ok && com_i == `T16WM_COM_TOGGLE && match_i);

endmodule
`default_nettype wire

// >>> dv/test_t16wm_top.sv
// Self-checking bench for the waveform mode control block.
`default_nettype none
`include "t16wm_regs.svh"
module test_t16wm_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Bench side of every port.
	logic        clk;
	logic        rst;
	logic [11:0] addr;
	logic        rd;
	logic        wr;
	logic [3:0]  be;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic        ten;
	logic        ddr_a;
	logic        port_a;
	logic        ddr_b;
	logic        port_b;
	logic        out_a;
	logic        oe_a;
	logic        out_b;
	logic        oe_b;
	logic        ovf;
	logic [15:0] cnt;
	int          fails;
	int          num_checks;
	logic [31:0] dummy;

	// The block under test.
	t16wm_top i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wdata),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .TIMER_CLK_EN_I(ten),
		.CHAN_A_DDR_I(ddr_a), .CHAN_A_PORT_I(port_a), .CHAN_B_DDR_I(ddr_b),
		.CHAN_B_PORT_I(port_b), .CHAN_A_WAVE_OUT_O(out_a), .CHAN_A_WAVE_OE_O(oe_a),
		.CHAN_B_WAVE_OUT_O(out_b), .CHAN_B_WAVE_OE_O(oe_b), .OVERFLOW_FLAG_O(ovf),
		.COUNTER_VALUE_O(cnt));

	// Clock of 20 ns period.
	always #10 clk = ~clk;

	// Compares one result and counts it.
	task automatic chk(input logic [31:0] e, input logic [31:0] a);
		num_checks++;
		if (a !== e)
		begin
			fails++;
			$display("mismatch at %0t: expected %h got %h", $time, e, a);
		end
	endtask

	// One Avalon access; the request stands until the rising edge that sees waitrequest low.
	// Read data is taken at that edge, the request is dropped there, and the task returns
	// at the following falling edge so that later checks see settled outputs.
	task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= {idx, 2'b00};
		wr <= w;
		rd <= !w;
		wdata <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk);
		if (n >= 50)
		begin
			fails++;
			$display("mismatch at %0t: bus hang", $time);
		end
	endtask

	// Register write.
	task automatic wrr(input logic [9:0] idx, input logic [31:0] d);
		bus(1'b1, idx, d, dummy);
	endtask

	// Register read and compare.
	task automatic rdchk(input logic [9:0] idx, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, q);
		chk(e, q);
	endtask

	// Waits, bounded, until the counter shows a value.
	task automatic wait_cnt(input logic [15:0] v);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (cnt !== v && n < 3000);
		if (n >= 3000)
		begin
			fails++;
			$display("mismatch at %0t: counter never reached %h", $time, v);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog of fifty thousand cycles, well above the few thousand the tests need.
	initial
	begin
		#(20 * 50000);
		fails++;
		$display("mismatch at %0t: watchdog expired", $time);
		summarize();
	end

	// Test sequence; mode 13 is never selected.
	initial
	begin
		clk = 0; rst = 1; rd = 0; wr = 0; addr = 0; be = 4'hF; wdata = 0; dummy = 0;
		ten = 1; ddr_a = 0; port_a = 0; ddr_b = 0; port_b = 1; fails = 0; num_checks = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// Reset values, read-only bits, pin ownership and drive enable.
		rdchk(`T16WM_IDX_CTRL_A, 32'h0000_0000);
		rdchk(10'h3FF, 32'h0000_0000);
		chk(1'b1, out_b);
		chk(1'b0, oe_a);
		chk(1'b0, oe_b);
		@(posedge clk);
		ddr_a <= 1'b1;
		repeat (3) @(negedge clk);
		chk(1'b1, oe_a);
		wrr(`T16WM_IDX_CTRL_A, 32'h0000_00FF);
		rdchk(`T16WM_IDX_CTRL_A, 32'h0000_00F3);
		$display("test registers done");
		// Normal mode raises the flag at MAX.
		wrr(`T16WM_IDX_CTRL_A, 32'h0);
		wrr(`T16WM_IDX_CTRL_B, 32'h0);
		wrr(`T16WM_IDX_STATUS, 32'h1);
		chk(1'b0, ovf);
		wrr(`T16WM_IDX_COUNT, 32'h0000_FFF0);
		wait_cnt(16'h0002);
		chk(1'b1, ovf);
		$display("test normal done");
		// Clear on match with TOP from compare A, channel A toggling then clear and set.
		wrr(`T16WM_IDX_CMP_A, 32'h0000_0020);
		wrr(`T16WM_IDX_CTRL_A, 32'h0000_0040);
		wrr(`T16WM_IDX_CTRL_B, 32'h0000_0008);
		wrr(`T16WM_IDX_STATUS, 32'h1);
		wait_cnt(16'h0020);
		@(negedge clk);
		chk(16'h0000, cnt);
		wait_cnt(16'h001F);
		dummy[0] = out_a;
		wait_cnt(16'h0002);
		chk(!dummy[0], out_a);
		for (int c = 2; c < 4; c++)
		begin
			wrr(`T16WM_IDX_CTRL_A, {24'h000000, c[1:0], 6'h00});
			wait_cnt(16'h001F);
			wait_cnt(16'h0002);
			chk(c - 2, out_a);
		end
		chk(1'b0, ovf);
		$display("test clear on match done");
		// Fast 8-bit mode, non-inverting then inverting; channel B toggle code stays off.
		wrr(`T16WM_IDX_CMP_A, 32'h0000_0010);
		wrr(`T16WM_IDX_CTRL_A, 32'h0000_0091);
		wait_cnt(16'h00FF);
		wrr(`T16WM_IDX_STATUS, 32'h1);
		wait_cnt(16'h000E);
		chk(1'b1, out_a);
		wait_cnt(16'h0013);
		chk(1'b0, out_a);
		chk(1'b1, out_b);
		chk(1'b0, ovf);
		wait_cnt(16'h0001);
		chk(1'b1, ovf);
		wrr(`T16WM_IDX_CTRL_A, 32'h0000_00C1);
		wait_cnt(16'h00FF);
		wait_cnt(16'h000E);
		chk(1'b0, out_a);
		wait_cnt(16'h0013);
		chk(1'b1, out_a);
		$display("test fast done");
		// Phase correct 8-bit mode: turn at TOP, flag at BOTTOM, dual-slope output.
		wrr(`T16WM_IDX_CTRL_A, 32'h0000_0081);
		wrr(`T16WM_IDX_CTRL_B, 32'h0);
		wait_cnt(16'h00FF);
		@(negedge clk);
		chk(16'h00FE, cnt);
		wait_cnt(16'h000D);
		chk(1'b1, out_a);
		wrr(`T16WM_IDX_STATUS, 32'h1);
		wait_cnt(16'h0000);
		repeat (2) @(negedge clk);
		chk(1'b1, ovf);
		wait_cnt(16'h0013);
		chk(1'b0, out_a);
		$display("test phase correct done");
		// Frequency correct mode 9: TOP from compare A, channel A toggles, channel B inverting.
		wrr(`T16WM_IDX_CMP_A, 32'h0000_0040);
		wrr(`T16WM_IDX_CMP_B, 32'h0000_0020);
		wrr(`T16WM_IDX_CTRL_A, 32'h0000_0071);
		wrr(`T16WM_IDX_CTRL_B, 32'h0000_0010);
		wrr(`T16WM_IDX_STATUS, 32'h1);
		chk(1'b0, ovf);
		wrr(`T16WM_IDX_COUNT, 32'h0);
		wait_cnt(16'h0030);
		chk(1'b1, ovf);
		chk(1'b1, out_b);
		dummy[0] = out_a;
		wait_cnt(16'h0030);
		chk(!dummy[0], out_a);
		wait_cnt(16'h0010);
		chk(1'b0, out_b);
		$display("test frequency correct done");
		// Without the timer clock enable the counter holds its value.
		@(posedge clk);
		ten <= 1'b0;
		repeat (2) @(negedge clk);
		dummy[15:0] = cnt;
		repeat (4) @(negedge clk);
		chk(dummy[15:0], cnt);
		$display("test clock enable done");
		summarize();
	end
endmodule
`default_nettype wire
